/* File: hw/sig_glue.sv */
// System integration glue: chip selects, external bus sequencer, GPIO pin
// muxing, interrupt controller, software watchdog and power/wake control.
// Assumes all inputs are synchronous to sys_clk and the core holds a request
// for one cycle only, waiting for core_ack_q before the next.
//
// Notes on behaviour
// R1: Four active-low range-decoded chip selects
// R2: Chip select honours read/write restriction
// R3: Match one function code or all
// R4: Internal acknowledge after zero to six waits
// R5: Word to 8-bit port split into bytes
// R6: Third select splits into four 16K selects
// R7: Drive 24 address and 16 data lines
// R8: Native or multiplexed 8-bit external cycles
// R9: Port A 8 bits, port B 16 bits
// R10: Per-pin choice of GPIO or peripheral
// R11: Peripheral keeps running when pins are GPIO
// R12: NMI input always requests level seven
// R13: Eight latched inputs, each own level
// R14: Clear one pending request individually
// R15: Peripheral levels and vectors on acknowledge
// R16: Unserviced watchdog resets the device
// R17: Interrupts wake a stopped core
// R18: Timer and receiver may trigger wake-up
// R19: Per-module software clock disable
// R20: Receive edge restarts receiver clock, then wakes
// R21: Software keeps timer/two-wire clocks on for wake
// R22: Latched request holds until software clears
`timescale 1ns/10ps
module sig_glue #(
   parameter int WD_PRESCALE = sig_pkg::WD_TICK_CYC
) (
   input  wire  logic                                        sys_clk,
   input  wire  logic                                        rst_n,
   input  wire  logic                                        core_req,
   input  wire  logic [sig_pkg::ADDR_W-1:0]                  core_addr,
   input  wire  logic                                        core_write,
   input  wire  logic [2:0]                                  core_fc,
   input  wire  logic                                        core_word,
   input  wire  logic [sig_pkg::DATA_W-1:0]                  core_wdata,
   output logic                                              core_ack_q,
   output logic [sig_pkg::DATA_W-1:0]                        core_rdata_q,
   input  wire  logic [sig_pkg::NUM_CS-1:0][sig_pkg::ADDR_W-1:0] cs_base,
   input  wire  logic [sig_pkg::NUM_CS-1:0][sig_pkg::ADDR_W-1:0] cs_mask,
   input  wire  logic [sig_pkg::NUM_CS-1:0][1:0]             cs_rw_mode,
   input  wire  logic [sig_pkg::NUM_CS-1:0]                  cs_fc_any,
   input  wire  logic [sig_pkg::NUM_CS-1:0][2:0]             cs_fc,
   input  wire  logic [sig_pkg::NUM_CS-1:0]                  cs_auto_ack,
   input  wire  logic [sig_pkg::NUM_CS-1:0][2:0]             cs_wait,
   input  wire  logic [sig_pkg::NUM_CS-1:0]                  cs_port8,
   input  wire  logic                                        periph_sel_en,
   input  wire  logic                                        mux_bus_en,
   input  wire  logic                                        transfer_ack_n,
   output logic [sig_pkg::NUM_CS-1:0]                        chip_select_n_q,
   output logic                                              periph_select_a_n_q,
   output logic                                              periph_select_b_n_q,
   output logic                                              periph_select_c_n_q,
   output logic                                              periph_select_d_n_q,
   output logic [sig_pkg::ADDR_W-1:0]                        ext_addr_q,
   output logic [sig_pkg::DATA_W-1:0]                        ext_data_o_q,
   output logic                                              ext_data_oe_q,
   input  wire  logic [sig_pkg::DATA_W-1:0]                  ext_data_i,
   output logic                                              ext_as_n_q,
   output logic                                              ext_rw_q,
   output logic                                              ext_ub_n_q,
   output logic                                              ext_lb_n_q,
   output logic                                              ext_ale_q,
   input  wire  logic [sig_pkg::GPIO_W-1:0]                  gpio_sel,
   input  wire  logic [sig_pkg::GPIO_W-1:0]                  gpio_dir,
   input  wire  logic [sig_pkg::GPIO_W-1:0]                  gpio_out,
   input  wire  logic [sig_pkg::GPIO_W-1:0]                  periph_pin_o,
   input  wire  logic [sig_pkg::GPIO_W-1:0]                  periph_pin_oe,
   input  wire  logic [sig_pkg::GPIO_W-1:0]                  pin_i,
   output logic [sig_pkg::GPIO_W-1:0]                        pin_o_q,
   output logic [sig_pkg::GPIO_W-1:0]                        pin_oe_q,
   output logic [sig_pkg::GPIO_W-1:0]                        gpio_in_q,
   output logic [sig_pkg::GPIO_W-1:0]                        periph_pin_i_q,
   input  wire  logic                                        nmi_request_n,
   input  wire  logic [sig_pkg::NUM_INT-1:0]                 latched_irq_n,
   input  wire  logic [sig_pkg::NUM_INT-1:0]                 int_clear,
   input  wire  logic [sig_pkg::NUM_INT-1:0][sig_pkg::LVL_W-1:0] int_level,
   input  wire  logic [sig_pkg::NUM_PER-1:0]                 periph_irq,
   input  wire  logic [sig_pkg::NUM_PER-1:0][sig_pkg::LVL_W-1:0] periph_level,
   input  wire  logic [sig_pkg::NUM_PER-1:0][sig_pkg::VEC_W-1:0] periph_vector,
   input  wire  logic                                        iack_req,
   input  wire  logic [sig_pkg::LVL_W-1:0]                   iack_level,
   output logic [sig_pkg::NUM_INT-1:0]                       int_pending_q,
   output logic [sig_pkg::LVL_W-1:0]                         core_ipl_q,
   output logic                                              iack_done_q,
   output logic                                              iack_auto_q,
   output logic [sig_pkg::VEC_W-1:0]                         iack_vector_q,
   input  wire  logic                                        wd_start,
   input  wire  logic                                        wd_service,
   input  wire  logic [sig_pkg::WD_W-1:0]                    wd_limit,
   output logic                                              wd_reset_q,
   output logic [sig_pkg::WD_W-1:0]                          wd_count_q,
   input  wire  logic                                        core_stopped,
   input  wire  logic [sig_pkg::NUM_PER-1:0]                 clk_en_sw,
   input  wire  logic                                        rxd_pin,
   input  wire  logic                                        uart_frame_done,
   output logic [sig_pkg::NUM_PER-1:0]                       mod_clk_en_q,
   output logic                                              core_wake_q
);
   import sig_pkg::*;

   // Address, direction and function-code qualification of one block
   function automatic logic cs_match(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
                                     input logic [ADDR_W-1:0] mask, input logic [1:0] mode,
                                     input logic wr, input logic any, input logic [2:0] fc,
                                     input logic [2:0] cfc);
      cs_match = (((a ^ base) & mask) == '0)                          // [R1]
                 && !(mode == RW_READ && wr) && !(mode == RW_WRITE && !wr) // [R2]
                 && (any || fc == cfc);                               // [R3]
   endfunction : cs_match

   // Highest level among the active sources; level 0 means no request
   function automatic logic [LVL_W-1:0] max_level(input logic [NUM_INT-1:0] act,
                                                  input logic [NUM_INT-1:0][LVL_W-1:0] lvl);
      max_level = '0;
      for (int i = 0; i < NUM_INT; i++)
         if (act[i] && lvl[i] > max_level)
            max_level = lvl[i];
   endfunction : max_level

   // ---------------- External bus sequencer ----------------
   sig_bus_state_t      state_q, state_d;
   logic [ADDR_W-1:0]   addr_q, addr_d;
   logic [DATA_W-1:0]   wdata_q, wdata_d, rdata_d;
   logic [1:0]          idx_q, idx_d;
   logic                hit_q, hit_d, write_q, write_d, narrow_q, narrow_d;
   logic                more_q, more_d, auto_q, auto_d, ack_d, word_q, word_d;
   logic [2:0]          wait_q, wait_d, wlim_q, wlim_d;
   logic                ack_now, glue_rst_n;
   logic [NUM_CS-1:0]   cs_n_d;
   logic [3:0]          psel_n_d;
   logic [ADDR_W-1:0]   off, ext_addr_d;
   logic [DATA_W-1:0]   data_o_d;
   logic                oe_d, as_n_d, rw_d, ub_n_d, lb_n_d, ale_d;

   // Next state of the sequencer and the pin values it will present
   always_comb
   begin
      state_d  = state_q;
      addr_d   = addr_q;
      wdata_d  = wdata_q;
      rdata_d  = core_rdata_q;
      idx_d    = idx_q;
      hit_d    = hit_q;
      write_d  = write_q;
      word_d   = word_q;
      narrow_d = narrow_q;
      more_d   = more_q;
      auto_d   = auto_q;
      wlim_d   = wlim_q;
      wait_d   = wait_q;
      ack_d    = 1'b0;
      // Internal acknowledge counts waits; otherwise the external one ends the cycle
      ack_now  = (hit_q && auto_q) ? (wait_q == wlim_q) : !transfer_ack_n; // [R4]
      case (state_q)
         BUS_IDLE:
            if (core_req)
            begin
               hit_d = 1'b0;
               idx_d = 2'h0;
               for (int i = NUM_CS - 1; i >= 0; i--)
                  if (cs_match(core_addr, cs_base[i], cs_mask[i], cs_rw_mode[i], core_write,
                               cs_fc_any[i], core_fc, cs_fc[i]))
                  begin
                     hit_d = 1'b1;
                     idx_d = 2'(i);
                  end
               addr_d   = core_addr;
               wdata_d  = core_wdata;
               write_d  = core_write;
               word_d   = core_word;
               auto_d   = cs_auto_ack[idx_d];
               wlim_d   = (cs_wait[idx_d] > MAX_WAIT) ? MAX_WAIT : cs_wait[idx_d];
               narrow_d = mux_bus_en || (hit_d && cs_port8[idx_d]);           // [R8]
               more_d   = core_word && narrow_d;                              // [R5]
               if (more_d)
                  addr_d[0] = 1'b0;
               wait_d   = 3'h0;
               state_d  = mux_bus_en ? BUS_ADDR : BUS_DATA;
            end
         BUS_ADDR:
            state_d = BUS_DATA;
         BUS_DATA:
         begin
            wait_d = wait_q + 3'h1;
            if (ack_now)
            begin
               if (!narrow_q)
                  rdata_d = ext_data_i;
               else if (addr_q[0])
                  rdata_d = {core_rdata_q[15:8], ext_data_i[7:0]};
               else
                  rdata_d = {ext_data_i[7:0], core_rdata_q[7:0]};
               state_d = BUS_GAP;
            end
         end
         BUS_GAP:
            if (more_q)
            begin
               // Second byte of a split word goes to the odd address
               more_d  = 1'b0;
               addr_d  = addr_q + 24'h000001;                                   // [R5]
               wait_d  = 3'h0;
               state_d = mux_bus_en ? BUS_ADDR : BUS_DATA;
            end
            else
            begin
               ack_d   = 1'b1;
               state_d = BUS_IDLE;
            end
         default:
            state_d = BUS_IDLE;
      endcase
      // Pin values follow the next state so every pin leaves a flip-flop
      off        = addr_d - cs_base[CS_PERIPH];
      cs_n_d     = '1;
      psel_n_d   = 4'hf;
      if (state_d == BUS_DATA && hit_d)
      begin
         if (periph_sel_en && idx_d == CS_PERIPH)
         begin
            if (off[ADDR_W-1:PSEL_SHIFT+2] == '0)
               psel_n_d[off[PSEL_SHIFT+1:PSEL_SHIFT]] = 1'b0;                  // [R6]
         end
         else
            cs_n_d[idx_d] = 1'b0;                                             // [R1]
      end
      ext_addr_d = addr_d;                                                    // [R7]
      ale_d      = (state_d == BUS_ADDR);
      as_n_d     = (state_d != BUS_DATA);
      rw_d       = !(write_d && state_d != BUS_IDLE);
      oe_d       = ale_d || (state_d == BUS_DATA && write_d);
      data_o_d   = wdata_d;
      ub_n_d     = 1'b1;
      lb_n_d     = 1'b1;
      // Multiplexed bus carries the low address byte in the ALE phase
      if (ale_d)
         data_o_d = {8'h00, addr_d[7:0]};                                     // [R8]
      else if (narrow_d)
         data_o_d = {8'h00, addr_d[0] ? wdata_d[7:0] : wdata_d[15:8]};
      if (state_d == BUS_DATA)
      begin
         ub_n_d = narrow_d || (!word_d && addr_d[0]);
         lb_n_d = !(narrow_d || word_d || addr_d[0]);
      end
   end

   // Watchdog expiry clears the glue for one cycle, like the reset pin
   assign glue_rst_n = rst_n && !wd_reset_q; // [R16]
   // Control pins reset to idle; datapath words are loaded in IDLE first
   always_ff @(posedge sys_clk)
   begin
      state_q <= glue_rst_n ? state_d : BUS_IDLE;
      core_ack_q <= glue_rst_n && ack_d;
      chip_select_n_q <= glue_rst_n ? cs_n_d : '1;
      {periph_select_d_n_q, periph_select_c_n_q,
       periph_select_b_n_q, periph_select_a_n_q} <= glue_rst_n ? psel_n_d : 4'hf;
      ext_as_n_q <= !glue_rst_n || as_n_d;
      ext_rw_q <= !glue_rst_n || rw_d;
      ext_ub_n_q <= !glue_rst_n || ub_n_d;
      ext_lb_n_q <= !glue_rst_n || lb_n_d;
      ext_ale_q <= glue_rst_n && ale_d;
      ext_data_oe_q <= glue_rst_n && oe_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      idx_q <= idx_d;
      hit_q <= hit_d;
      write_q <= write_d;
      word_q <= word_d;
      narrow_q <= narrow_d;
      more_q <= more_d;
      auto_q <= auto_d;
      wait_q <= wait_d;
      wlim_q <= wlim_d;
      core_rdata_q <= rdata_d;
      ext_addr_q <= ext_addr_d;
      ext_data_o_q <= data_o_d;
   end

   // Pins, interrupts, module clocks and watchdog
   logic [GPIO_W-1:0]  pin_o_d, pin_oe_d;
   logic [NUM_INT-1:0] pend_d;
   logic [LVL_W-1:0]   ipl_d, per_lvl;
   logic [VEC_W-1:0]   vec_d;
   logic [WD_W-1:0]    cnt_d, pre_q, pre_d;
   logic [NUM_PER-1:0] clk_en_d;
   logic               auto_v_d, wake_d, rxd_q, rx_run_q, rx_run_d;
   logic               wd_run_q, wd_run_d, wd_tick, wd_fire;
   // Next values; a set beats a clear that falls in the same cycle
   always_comb
   begin
      pin_o_d  = (gpio_sel & gpio_out) | (~gpio_sel & periph_pin_o); // [R9] [R10]
      pin_oe_d = (gpio_sel & gpio_dir) | (~gpio_sel & periph_pin_oe); // [R10]
      pend_d   = (int_pending_q & ~int_clear) | ~latched_irq_n; // [R13] [R14] [R22]
      per_lvl  = max_level({{(NUM_INT-NUM_PER){1'b0}}, periph_irq},
                           {{((NUM_INT-NUM_PER)*LVL_W){1'b0}}, periph_level}); // [R15]
      ipl_d    = max_level(int_pending_q, int_level); // [R13]
      if (per_lvl > ipl_d)
         ipl_d = per_lvl;
      if (!nmi_request_n)
         ipl_d = NMI_LEVEL; // [R12]
      // A level no peripheral claims is answered by autovector
      vec_d    = iack_vector_q;
      auto_v_d = iack_req || iack_auto_q;
      for (int i = NUM_PER - 1; i >= 0; i--)
         if (iack_req && periph_irq[i] && periph_level[i] == iack_level)
         begin
            auto_v_d = 1'b0;
            vec_d    = periph_vector[i]; // [R15]
         end
      // The controller runs while the core sleeps, so any request wakes it
      wake_d   = core_stopped && (ipl_d != '0 || uart_frame_done); // [R17] [R18] [R20]
      // Only the receiver restarts its own clock; timer and two-wire do not
      rx_run_d = (rx_run_q && !uart_frame_done) || rxd_pin != rxd_q; // [R20]
      clk_en_d = clk_en_sw; // [R19]
      clk_en_d[MOD_UART] = clk_en_sw[MOD_UART] || rx_run_d; // [R20]
      wd_tick  = wd_run_q && pre_q == WD_W'(WD_PRESCALE - 1);
      wd_fire  = wd_tick && wd_count_q == wd_limit && !wd_reset_q; // [R16]
      wd_run_d = wd_run_q || wd_start;
      pre_d    = (wd_tick || wd_start || wd_service) ? '0 : pre_q + 16'h0001;
      cnt_d    = wd_count_q + WD_W'(wd_tick);
      if (wd_start || wd_service)
         cnt_d = '0; // [R16]
   end
   // Receive pin idles high, so its copy resets high: no false edge
   always_ff @(posedge sys_clk)
   begin
      pin_o_q <= pin_o_d;
      pin_oe_q <= glue_rst_n ? pin_oe_d : '0;
      gpio_in_q <= pin_i;
      periph_pin_i_q <= pin_i; // [R11]
      int_pending_q <= glue_rst_n ? pend_d : '0;
      core_ipl_q <= glue_rst_n ? ipl_d : '0;
      iack_done_q <= glue_rst_n && iack_req;
      iack_auto_q <= glue_rst_n && auto_v_d;
      iack_vector_q <= glue_rst_n ? vec_d : '0;
      core_wake_q <= glue_rst_n && wake_d;
      rxd_q <= !glue_rst_n || rxd_pin;
      rx_run_q <= glue_rst_n && rx_run_d;
      mod_clk_en_q <= glue_rst_n ? clk_en_d : '1;
      wd_run_q <= glue_rst_n && wd_run_d;
      pre_q <= glue_rst_n ? pre_d : '0;
      wd_count_q <= glue_rst_n ? cnt_d : '0;
      wd_reset_q <= rst_n && wd_fire;
   end

   // Expiry gives a one-cycle reset that also stops the watchdog
   sequence s_wd_pulse;
      wd_reset_q ##1 (!wd_reset_q && !wd_run_q);
   endsequence
   a_cs_onehot: assert property (@(posedge sys_clk) disable iff (!glue_rst_n) // [R1]
      $onehot0(~chip_select_n_q)) else $error("chip selects overlap");
   a_ack_pulse: assert property (@(posedge sys_clk) disable iff (!glue_rst_n) // [R4]
      core_ack_q |=> !core_ack_q) else $error("acknowledge too long");
   a_nmi_level: assert property (@(posedge sys_clk) disable iff (!glue_rst_n) // [R12]
      !nmi_request_n |=> core_ipl_q == NMI_LEVEL) else $error("nmi level wrong");
   a_pend_hold: assert property (@(posedge sys_clk) disable iff (!glue_rst_n) // [R22]
      int_clear == '0 |=> (int_pending_q & $past(int_pending_q)) == $past(int_pending_q))
      else $error("pending request lost");
   a_rx_restart: assert property (@(posedge sys_clk) disable iff (!glue_rst_n) // [R20]
      rxd_pin != rxd_q |=> mod_clk_en_q[MOD_UART]) else $error("receive clock off");
   a_wd_reset: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R16]
      wd_fire |=> s_wd_pulse) else $error("watchdog reset missing");
endmodule : sig_glue

/* File: shared/sig_pkg.sv */
// Constants, widths and state types for the system integration glue.
// Assumes a single 200 MHz clock domain; no register bus, all settings are ports.
package sig_pkg;
   // Bus and port widths
   localparam int ADDR_W  = 24;
   localparam int DATA_W  = 16;
   localparam int NUM_CS  = 4;
   localparam int GPIO_W  = 24;          // Port A in bits 7:0, port B in bits 23:8
   localparam int NUM_INT = 8;
   localparam int NUM_PER = 4;
   localparam int LVL_W   = 3;
   localparam int VEC_W   = 8;
   localparam int WD_W    = 16;
   // Chip-select options
   localparam logic [1:0] RW_BOTH    = 2'h0;
   localparam logic [1:0] RW_READ    = 2'h1;
   localparam logic [1:0] RW_WRITE   = 2'h2;
   localparam logic [2:0] MAX_WAIT   = 3'h6;
   localparam logic [1:0] CS_PERIPH  = 2'h2;
   localparam int         PSEL_SHIFT = 14;   // 16-Kbyte sub-select blocks
   // Interrupt levels
   localparam logic [2:0] NMI_LEVEL  = 3'h7;
   // Module clock enable positions
   localparam int MOD_TIMER = 0;
   localparam int MOD_UART  = 1;
   localparam int MOD_TWI   = 2;
   localparam int MOD_EBUS  = 3;
   // Watchdog tick: time in ns, cycles derived from the clock period
   localparam int CLK_NS      = 5;
   localparam int WD_TICK_NS  = 1000;
   localparam int WD_TICK_CYC = (WD_TICK_NS + CLK_NS - 1) / CLK_NS;
   // External bus sequencer states
   typedef enum logic [1:0] {BUS_IDLE, BUS_ADDR, BUS_DATA, BUS_GAP} sig_bus_state_t;
endpackage : sig_pkg

/* File: verification/sig_ext_mem.sv */
// External memory model on the glue's native bus.
// Assumes strobes change on sys_clk rising edges; ack_delay counts strobe cycles.
`timescale 1ns/10ps
module sig_ext_mem
(
   input  wire logic        sys_clk,
   input  wire logic [3:0]  ack_delay,
   input  wire logic        as_n,
   input  wire logic        rw,
   input  wire logic [23:0] addr,
   output logic             ack_n,
   output logic [15:0]      rdata
);
   logic [3:0]  cnt_q;
   logic [15:0] last_q = 16'h0;
   // Count strobe cycles; a large delay lets the glue's own acknowledge win
   always @(posedge sys_clk)
   begin
      cnt_q <= as_n ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hf};
      last_q <= rdata;
   end
   assign ack_n = as_n | (cnt_q < ack_delay);
   // Released bus shows the inverse of the last value, never a stale copy
   assign rdata = (!as_n && rw) ? {addr[7:0], ~addr[7:0]} : ~last_q;
endmodule : sig_ext_mem

/* File: verification/sig_glue_bench.sv */
// Bench for the system glue: selects, bus, pins, interrupts, wake and watchdog.
// Assumes the memory model on the native bus; all settings are driven as ports.
`timescale 1ns/10ps
module sig_glue_bench;
   import sig_pkg::*;
   localparam int PRE = 2;
   logic sys_clk = 1'b0, rst_n = 1'b0, core_req = 1'b0, core_write = 1'b0, core_word = 1'b1;
   logic periph_sel_en = 1'b0, mux_bus_en = 1'b0, nmi_request_n = 1'b1, iack_req = 1'b0;
   logic wd_start = 1'b0, wd_service = 1'b0, core_stopped = 1'b0, rxd_pin = 1'b1, ales;
   logic uart_frame_done = 1'b0, transfer_ack_n, core_ack_q, ext_data_oe_q, ext_as_n_q;
   logic ext_rw_q, ext_ub_n_q, ext_lb_n_q, ext_ale_q, iack_done_q, iack_auto_q, wd_reset_q;
   logic core_wake_q, periph_select_a_n_q, periph_select_b_n_q, periph_select_c_n_q;
   logic periph_select_d_n_q;
   logic [2:0] core_fc = 3'h2, iack_level = 3'h0, core_ipl_q;
   logic [ADDR_W-1:0] core_addr = 24'h0, ext_addr_q;
   logic [DATA_W-1:0] core_wdata = 16'h3c5a, core_rdata_q, ext_data_o_q, ext_data_i, rd_got;
   logic [NUM_CS-1:0][ADDR_W-1:0] cs_base = {24'h300000, 24'h100000, 24'h200000, 24'h0};
   logic [NUM_CS-1:0][ADDR_W-1:0] cs_mask = {4{24'hff0000}};
   logic [NUM_CS-1:0][2:0] cs_fc = 12'h0, cs_wait = 12'h0;
   logic [NUM_CS-1:0][1:0] cs_rw_mode = 8'h0;
   logic [NUM_CS-1:0] cs_fc_any = 4'hf, cs_auto_ack = 4'hf, cs_port8 = 4'h0, chip_select_n_q;
   logic [GPIO_W-1:0] gpio_sel = 24'h00ff0f, gpio_dir = 24'h0000ff, gpio_out = 24'h123456;
   logic [GPIO_W-1:0] periph_pin_o = 24'hfedcba, periph_pin_oe = 24'hff0000;
   logic [GPIO_W-1:0] ext_pins = 24'ha5c33c, pin_o_q, pin_oe_q, gpio_in_q, periph_pin_i_q;
   logic [GPIO_W-1:0] pin_i, exp_oe;
   logic [NUM_INT-1:0] latched_irq_n = 8'hff, int_clear = 8'h0, int_pending_q;
   logic [NUM_INT-1:0][LVL_W-1:0] int_level = {3'h0, 3'h0, 3'h5, 3'h0, 3'h0, 3'h3, 6'h0};
   logic [NUM_PER-1:0] periph_irq = 4'h0, clk_en_sw = 4'hf, mod_clk_en_q;
   logic [NUM_PER-1:0][LVL_W-1:0] periph_level = 12'h020;
   logic [NUM_PER-1:0][VEC_W-1:0] periph_vector = 32'h00004200;
   logic [VEC_W-1:0] iack_vector_q;
   logic [WD_W-1:0] wd_limit = 16'h8, wd_count_q;
   logic [3:0] ack_delay = 4'hf, cs_seen, ps_seen;
   int num_errors = 0, checked = 0, cyc, strobes;
   sig_glue #(.WD_PRESCALE(PRE)) dut_u
   (
      .sys_clk, .rst_n, .core_req, .core_addr, .core_write, .core_fc, .core_word, .core_wdata,
      .core_ack_q, .core_rdata_q, .cs_base, .cs_mask, .cs_rw_mode, .cs_fc_any, .cs_fc,
      .cs_auto_ack, .cs_wait, .cs_port8, .periph_sel_en, .mux_bus_en, .transfer_ack_n,
      .chip_select_n_q, .periph_select_a_n_q, .periph_select_b_n_q, .periph_select_c_n_q,
      .periph_select_d_n_q, .ext_addr_q, .ext_data_o_q, .ext_data_oe_q, .ext_data_i,
      .ext_as_n_q, .ext_rw_q, .ext_ub_n_q, .ext_lb_n_q, .ext_ale_q, .gpio_sel, .gpio_dir,
      .gpio_out, .periph_pin_o, .periph_pin_oe, .pin_i, .pin_o_q, .pin_oe_q, .gpio_in_q,
      .periph_pin_i_q, .nmi_request_n, .latched_irq_n, .int_clear, .int_level, .periph_irq,
      .periph_level, .periph_vector, .iack_req, .iack_level, .int_pending_q, .core_ipl_q,
      .iack_done_q, .iack_auto_q, .iack_vector_q, .wd_start, .wd_service, .wd_limit,
      .wd_reset_q, .wd_count_q, .core_stopped, .clk_en_sw, .rxd_pin, .uart_frame_done,
      .mod_clk_en_q, .core_wake_q
   );
   sig_ext_mem mem_u (.sys_clk, .ack_delay, .as_n(ext_as_n_q), .rw(ext_rw_q),
      .addr(ext_addr_q), .ack_n(transfer_ack_n), .rdata(ext_data_i));
   // Pin wire: our drive where enabled, the board's level elsewhere
   assign pin_i = (pin_o_q & pin_oe_q) | (ext_pins & ~pin_oe_q);
   // Clock and run limit, well above the expected few hundred cycles
   initial forever #2.5 sys_clk = ~sys_clk;
   initial
   begin
      #100000;
      num_errors++;
      close_out();
   end
   task automatic close_out();
      if (num_errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      num_errors += int'(got !== exp);
   endtask : cmp
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : tick
   task automatic wait_hi(ref logic s);
      for (cyc = 0; cyc < 40 && s !== 1'b1; cyc++)
         @(negedge sys_clk);
      cmp(s, 1'b1);
   endtask : wait_hi
   // One core access; notes selects, strobe starts and latch pulses until acknowledged
   task automatic access(input logic [23:0] a, input logic wr);
      logic as_q;
      {as_q, cs_seen, ps_seen, ales, strobes} = {1'b1, 9'h0, 32'h0};
      core_addr = a;
      core_write = wr;
      core_req = 1'b1;
      for (cyc = 0; cyc < 60 && core_ack_q !== 1'b1; cyc++)
      begin
         @(negedge sys_clk);
         core_req = 1'b0;
         cs_seen |= ~chip_select_n_q;
         ps_seen |= ~{periph_select_d_n_q, periph_select_c_n_q, periph_select_b_n_q,
                      periph_select_a_n_q};
         strobes += int'(as_q & ~ext_as_n_q);
         ales |= ext_ale_q;
         as_q = ext_as_n_q;
      end
      rd_got = core_rdata_q;
      tick(1);
   endtask : access
   task automatic t_cs();
      int c0;
      access(24'h000010, 1'b0);
      c0 = cyc;
      cmp(cs_seen, 4'h1);
      cmp(rd_got, 16'h10ef);
      cs_wait[0] = MAX_WAIT;
      access(24'h000010, 1'b0);
      cmp(cyc - c0, 6);
      cs_rw_mode[1] = RW_READ;
      access(24'h200000, 1'b1);
      cmp(cs_seen, 4'h0);
      cs_rw_mode[1] = RW_WRITE;
      cs_port8[1] = 1'b1;
      access(24'h200000, 1'b1);
      cmp(cs_seen, 4'h2);
      cmp(strobes, 2);
      {cs_fc_any[3], cs_fc[3]} = 4'h5;
      access(24'h300000, 1'b0);
      cmp(cs_seen, 4'h0);
      core_fc = 3'h5;
      access(24'h300000, 1'b0);
      cmp(cs_seen, 4'h8);
      periph_sel_en = 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         access(24'h100000 + 24'(k << PSEL_SHIFT), 1'b0);
         cmp({cs_seen[2], ps_seen}, 5'h1 << k);
      end
      mux_bus_en = 1'b1;
      access(24'h000020, 1'b0);
      cmp(ales, 1'b1);
      mux_bus_en = 1'b0;
   endtask : t_cs
   // Latched inputs held past release, cleared singly, then the level-7 input
   task automatic t_irq();
      latched_irq_n = 8'hdb;
      tick(3);
      latched_irq_n = 8'hff;
      tick(4);
      cmp(int_pending_q, 8'h24);
      cmp(core_ipl_q, 3'h5);
      int_clear = 8'h20;
      tick(1);
      int_clear = 8'h00;
      tick(4);
      cmp(int_pending_q, 8'h04);
      nmi_request_n = 1'b0;
      tick(4);
      cmp(core_ipl_q, NMI_LEVEL);
      nmi_request_n = 1'b1;
      int_clear = 8'h04;
      tick(1);
      int_clear = 8'h00;
   endtask : t_irq
   // Wake from a peripheral, its acknowledge vector, clock gating and receive restart
   task automatic t_pwr();
      core_stopped = 1'b1;
      periph_irq[1] = 1'b1;
      wait_hi(core_wake_q);
      core_stopped = 1'b0;
      tick(2);
      cmp(core_ipl_q, 3'h4);
      {iack_level, iack_req} = 4'h9;
      tick(1);
      iack_req = 1'b0;
      wait_hi(iack_done_q);
      cmp(iack_vector_q, 8'h42);
      cmp(iack_auto_q, 1'b0);
      periph_irq[1] = 1'b0;
      clk_en_sw[MOD_UART] = 1'b0; // Timer and two-wire stay on
      tick(3);
      cmp(mod_clk_en_q[MOD_UART], 1'b0);
      rxd_pin = 1'b0;
      tick(3);
      cmp(mod_clk_en_q[MOD_UART], 1'b1);
   endtask : t_pwr
   task automatic t_pins();
      exp_oe = (gpio_sel & gpio_dir) | (~gpio_sel & periph_pin_oe);
      tick(3);
      cmp(pin_oe_q, exp_oe);
      cmp(pin_o_q & exp_oe, ((gpio_sel & gpio_out) | (~gpio_sel & periph_pin_o)) & exp_oe);
      gpio_sel = 24'hffffff;
      tick(3);
      cmp(periph_pin_i_q, (gpio_out & gpio_dir) | (ext_pins & ~gpio_dir));
      cmp(gpio_in_q, (gpio_out & gpio_dir) | (ext_pins & ~gpio_dir));
   endtask : t_pins
   // Serviced watchdog stays quiet; a neglected one fires after the limit
   task automatic t_wd();
      wd_start = 1'b1;
      tick(1);
      wd_start = 1'b0;
      repeat (10)
      begin
         tick(6);
         wd_service = 1'b1;
         tick(1);
         wd_service = 1'b0;
      end
      cmp(wd_reset_q, 1'b0);
      wait_hi(wd_reset_q);
      cmp(cyc > 8, 1'b1);
   endtask : t_wd
   initial
   begin
      tick(12);
      rst_n = 1'b1;
      tick(2);
      t_cs();
      t_irq();
      t_pwr();
      t_pins();
      t_wd();
      rst_n = 1'b0;
      tick(12);
      rst_n = 1'b1;
      tick(2);
      cmp(wd_reset_q, 1'b0);
      close_out();
   end
endmodule : sig_glue_bench
